// *** hw/sfp_pkg.sv ***
package sfp_pkg;
    // Command codes
    localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] CMD_WRITE_LOCK   = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ  = 8'h05;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_SECTOR_WIPE  = 8'h20;
    localparam logic [7:0] CMD_BLOCK_WIPE   = 8'hd8;
    localparam logic [7:0] CMD_CHIP_WIPE    = 8'hc7;
    localparam logic [7:0] CMD_SLEEP_ENTER  = 8'hb9;
    localparam logic [7:0] CMD_SLEEP_EXIT   = 8'hab;

    // Status bit positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL  = 1;
    localparam int BIT_BPLO = 2;
    localparam int BIT_BPHI = 4;
    localparam int BIT_TB   = 5;
    localparam int BIT_RSV6 = 6;
    localparam int BIT_LOCK = 7;
    localparam logic [7:0] STATUS_WRITE_MASK = 8'hbc;
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam logic [2:0] BP_NONE = 3'h0;
    localparam logic [2:0] BP_ALL  = 3'h7;

    // Geometry
    localparam int ADDR_W      = 22;
    localparam int BLOCK_IDX_W = 6;
    localparam int PAGE_BYTES  = 256;

    // Internal cycle times (microseconds at CLK_MHZ; program and erase shortened in simulation)
    localparam int CLK_MHZ     = 10;
    localparam int T_WRITE_US  = 10;
    localparam int T_PROG_US   = 1500;

    typedef enum logic [2:0] {
        SFP_OP_NONE,
        SFP_OP_STATUS,
        SFP_OP_PROGRAM,
        SFP_OP_SECTOR,
        SFP_OP_BLOCK,
        SFP_OP_CHIP
    } sfp_op_t;
endpackage

// *** hw/sfp_sync.sv ***
module sfp_sync
    import sfp_pkg::*;
#(
    parameter int WIDTH = 4
)(
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sfp_sync_t;

    sfp_sync_t st;
    sfp_sync_t next_st;

    always_comb
    begin
        next_st.stage1 = asyncIn;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            st <= '0;
        else
            st <= next_st;
    end

    assign syncOut = st.stage2;
endmodule

// *** hw/sfp_region.sv ***
module sfp_region
    import sfp_pkg::*;
(
    input  wire logic [2:0]             blockProtect,
    input  wire logic                   topBottomSelect,
    input  wire logic [BLOCK_IDX_W-1:0] blockIdx,
    input  wire logic                   wholeChip,
    output logic                        isProtected
);
    logic [BLOCK_IDX_W:0] count;
    logic [BLOCK_IDX_W:0] idx;

    // code to block count
    // Blocks protected: 0, 1..32 by powers of two, or all 64
    always_comb
    begin
        idx = {1'b0, blockIdx};
        count = '0;
        if (blockProtect == BP_ALL)
            count = (BLOCK_IDX_W+1)'(1 << BLOCK_IDX_W);
        else if (blockProtect != BP_NONE)
            count = (BLOCK_IDX_W+1)'(1 << (blockProtect - 3'h1));
        if (count == '0)
            isProtected = 1'b0;
        else if (wholeChip)
            isProtected = 1'b1;
        else if (topBottomSelect)
            isProtected = idx < count;
        else
            isProtected = idx >= ((BLOCK_IDX_W+1)'(1 << BLOCK_IDX_W) - count);
    end
endmodule

// *** hw/sfp_status_protect.sv ***
// Behaviour
// - Busy flag set during internal cycles
// - Busy clears when cycle finishes
// - Write unlock sets enable latch
// - Latch clears at reset and after writes
// - Three block protect bits, default zero
// - Lock plus low pin blocks protect writes
// - Top/bottom bit picks protected end
// - Reserved bit six reads zero
// - Status lock bit gates by protect pin
// - Writes need whole multiple-of-eight clocks
// - Modifying commands need latch set
// - Protect codes decode to block counts
// - Protected addresses ignore program and erase
// - Page program stays in one page; code only pulses programStart with targetAddr
// - Erase sets bytes to all ones; code only pulses eraseStart with targetAddr
// - Active until cycle ends, then standby
// - Sleep ignores all but exit
// - Only exit command leaves sleep
// - Unlock 06h, lock 04h single byte
// - Status write changes bits 7,5,4,3,2
// - Status read repeats until deselect
module sfp_status_protect
    import sfp_pkg::*;
#(
    parameter int WRITE_CYCLES = T_WRITE_US * CLK_MHZ,
    parameter int PROG_CYCLES  = T_PROG_US * CLK_MHZ,
    parameter int ERASE_CYCLES = 20000
)(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              spiClk,
    input  wire logic              chipSelectN,
    input  wire logic              dataIn,
    input  wire logic              writeProtectN,
    output logic                   dataOut,
    output logic                   dataOutEn,
    output logic [7:0]             statusAndProtect,
    output logic                   eraseStart,
    output logic                   programStart,
    output logic [ADDR_W-1:0]      targetAddr,
    output logic                   eraseChip,
    output logic                   standby,
    output logic                   sleepActive
);
    typedef enum logic [1:0] {
        SFP_IDLE,
        SFP_CMD,
        SFP_TAIL
    } sfp_state_t;

    typedef struct packed {
        sfp_state_t        state;
        logic [7:0]        shiftIn;
        logic [2:0]        bitCnt;
        logic [5:0]        byteCnt;
        logic [7:0]        opcode;
        logic [23:0]       addr;
        logic [7:0]        statusData;
        logic [7:0]        outShift;
        logic              out;
        logic              outEn;
        logic              prevClk;
        logic              writeEnableLatch;
        logic [2:0]        blockProtect;
        logic              topBottomSelect;
        logic              statusLockBit;
        logic              cycleActiveFlag;
        sfp_op_t           op;
        logic [31:0]       timer;
        logic [7:0]        pendStatus;
        logic              sleep;
        logic              eraseStart;
        logic              programStart;
        logic [ADDR_W-1:0] target;
        logic              chip;
    } sfp_state_s_t;

    sfp_state_s_t st;
    sfp_state_s_t next_st;

    logic [3:0] pins;
    logic       sClk;
    logic       sCsN;
    logic       sDin;
    logic       sWpN;
    logic       isProt;
    logic [7:0] statusView;

    sfp_sync #(
        .WIDTH(4)
    ) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .asyncIn({spiClk, chipSelectN, dataIn, writeProtectN}),
        .syncOut(pins)
    );

    assign sClk = pins[3];
    assign sCsN = pins[2];
    assign sDin = pins[1];
    assign sWpN = pins[0];

    function automatic logic needs_latch(input logic [7:0] code);
        return code == CMD_STATUS_WRITE || code == CMD_PAGE_PROGRAM ||
               code == CMD_SECTOR_WIPE || code == CMD_BLOCK_WIPE ||
               code == CMD_CHIP_WIPE;
    endfunction

    sfp_region u_region (
        .blockProtect(st.blockProtect),
        .topBottomSelect(st.topBottomSelect),
        .blockIdx(st.addr[ADDR_W-1 -: BLOCK_IDX_W]),
        .wholeChip(st.opcode == CMD_CHIP_WIPE),
        .isProtected(isProt)
    );

    // Live status byte
    always_comb
    begin
        statusView = STATUS_RESET;
        statusView[BIT_BUSY] = st.cycleActiveFlag;
        statusView[BIT_WEL] = st.writeEnableLatch;
        statusView[BIT_BPHI:BIT_BPLO] = st.blockProtect;
        statusView[BIT_TB] = st.topBottomSelect;
        statusView[BIT_RSV6] = 1'b0;
        statusView[BIT_LOCK] = st.statusLockBit;
    end

    always_comb
    begin
        logic       rise;
        logic       fall;
        logic [7:0] byteNow;
        logic       whole;
        logic       cmdOk;
        rise = sClk && !st.prevClk;
        fall = !sClk && st.prevClk;
        byteNow = {st.shiftIn[6:0], sDin};
        whole = (st.bitCnt == 3'h0);
        cmdOk = 1'b0;
        next_st = st;
        next_st.prevClk = sClk;
        next_st.eraseStart = 1'b0;
        next_st.programStart = 1'b0;

        if (st.cycleActiveFlag)
        begin
            if (st.timer == 32'h0)
            begin
                next_st.cycleActiveFlag = 1'b0;
                if (st.op == SFP_OP_STATUS)
                begin
                    next_st.statusLockBit = st.pendStatus[BIT_LOCK];
                    next_st.topBottomSelect = st.pendStatus[BIT_TB];
                    next_st.blockProtect = st.pendStatus[BIT_BPHI:BIT_BPLO];
                end
                next_st.op = SFP_OP_NONE;
            end
            else
                next_st.timer = st.timer - 32'h1;
        end

        case (st.state)
            SFP_IDLE:
            begin
                next_st.outEn = 1'b0;
                if (!sCsN)
                begin
                    next_st.state = SFP_CMD;
                    next_st.bitCnt = '0;
                    next_st.byteCnt = '0;
                end
            end
            SFP_CMD, SFP_TAIL:
            begin
                if (sCsN)
                begin
                    next_st.state = SFP_IDLE;
                    next_st.outEn = 1'b0;
                    cmdOk = whole && st.byteCnt != '0 &&
                            !st.cycleActiveFlag && !st.sleep;
                    if (needs_latch(st.opcode) && !st.writeEnableLatch)
                        cmdOk = 1'b0;
                    if (cmdOk)
                    begin
                        case (st.opcode)
                            CMD_WRITE_UNLOCK:
                                next_st.writeEnableLatch = 1'b1;
                            CMD_WRITE_LOCK:
                                next_st.writeEnableLatch = 1'b0;
                            CMD_SLEEP_ENTER:
                                next_st.sleep = 1'b1;
                            CMD_STATUS_WRITE:
                            begin
                                // pin gated only when lock set
                                if (st.byteCnt >= 6'h2 &&
                                    !(st.statusLockBit && !sWpN))
                                begin
                                    next_st.pendStatus =
                                        st.statusData & STATUS_WRITE_MASK;
                                    next_st.op = SFP_OP_STATUS;
                                    next_st.cycleActiveFlag = 1'b1;
                                    next_st.timer = 32'(WRITE_CYCLES);
                                    next_st.writeEnableLatch = 1'b0;
                                end
                            end
                            CMD_PAGE_PROGRAM, CMD_SECTOR_WIPE,
                            CMD_BLOCK_WIPE, CMD_CHIP_WIPE:
                            begin
                                if ((st.opcode == CMD_CHIP_WIPE ||
                                     st.byteCnt >= 6'h4) && !isProt)
                                begin
                                    next_st.cycleActiveFlag = 1'b1;
                                    next_st.writeEnableLatch = 1'b0;
                                    next_st.target = st.addr[ADDR_W-1:0];
                                    next_st.chip =
                                        st.opcode == CMD_CHIP_WIPE;
                                    if (st.opcode == CMD_PAGE_PROGRAM)
                                    begin
                                        next_st.op = SFP_OP_PROGRAM;
                                        next_st.programStart = 1'b1;
                                        next_st.timer = 32'(PROG_CYCLES);
                                    end
                                    else
                                    begin
                                        next_st.op = SFP_OP_SECTOR;
                                        next_st.eraseStart = 1'b1;
                                        next_st.timer = 32'(ERASE_CYCLES);
                                    end
                                end
                            end
                            default:
                            begin
                            end
                        endcase
                    end
                    if (st.sleep && st.opcode == CMD_SLEEP_EXIT &&
                        st.byteCnt != '0)
                        next_st.sleep = 1'b0;
                end
                else if (rise)
                begin
                    next_st.shiftIn = byteNow;
                    next_st.bitCnt = st.bitCnt + 3'h1;
                    if (st.bitCnt == 3'h7)
                    begin
                        if (st.byteCnt != 6'h3f)
                            next_st.byteCnt = st.byteCnt + 6'h1;
                        if (st.byteCnt == '0)
                        begin
                            next_st.opcode = byteNow;
                            next_st.state = SFP_TAIL;
                            next_st.outShift = statusView;
                        end
                        else if (st.byteCnt <= 6'h3)
                            next_st.addr = {st.addr[15:0], byteNow};
                        if (st.byteCnt == 6'h1)
                            next_st.statusData = byteNow;
                    end
                end
                else if (fall && st.state == SFP_TAIL &&
                         st.opcode == CMD_STATUS_READ && !st.sleep)
                begin
                    next_st.outEn = 1'b1;
                    if (st.bitCnt == 3'h0)
                    begin
                        // Fresh byte: MSB now, rest queued
                        next_st.out = statusView[7];
                        next_st.outShift = {statusView[6:0], 1'b0};
                    end
                    else
                    begin
                        next_st.out = st.outShift[7];
                        next_st.outShift = {st.outShift[6:0], 1'b0};
                    end
                end
            end
            default:
                next_st.state = SFP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
            st.state <= SFP_IDLE;
            st.op <= SFP_OP_NONE;
            st.prevClk <= 1'b0;
        end
        else
            st <= next_st;
    end

    assign dataOut = st.out;
    assign dataOutEn = st.outEn;
    assign statusAndProtect = statusView;
    assign eraseStart = st.eraseStart;
    assign programStart = st.programStart;
    assign targetAddr = st.target;
    assign eraseChip = st.chip;
    assign standby = sCsN && !st.cycleActiveFlag;
    assign sleepActive = st.sleep;
endmodule

// *** sim/sfp_status_protect_properties.sv ***
module sfp_status_protect_properties
    import sfp_pkg::*;
#(
    parameter int WRITE_CYCLES = 100,
    parameter int PROG_CYCLES  = 15000,
    parameter int ERASE_CYCLES = 20000
)(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       chipSelectN,
    input wire logic       dataOutEn,
    input wire logic [7:0] statusAndProtect,
    input wire logic       eraseStart,
    input wire logic       programStart,
    input wire logic       standby,
    input wire logic       sleepActive
);
    localparam int MAX_BUSY = ERASE_CYCLES + PROG_CYCLES + WRITE_CYCLES + 2;
    logic [15:0] busyCnt;
    logic [15:0] next_busyCnt;
    logic        busy;
    logic        write_enable_latch;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    assign busy = statusAndProtect[BIT_BUSY];
    assign write_enable_latch  = statusAndProtect[BIT_WEL];
    assign next_busyCnt = busy ? busyCnt + 16'h1 : 16'h0;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            busyCnt <= 16'h0;
        else
            busyCnt <= next_busyCnt;
    end

    a_erase_pulse: assert property (eraseStart |=> !eraseStart)
        else $error("erase start longer than one cycle");
    a_prog_pulse: assert property (programStart |=> !programStart)
        else $error("program start longer than one cycle");
    a_start_busy: assert property ((eraseStart || programStart)
        |-> ##[0:1] busy) else $error("start without busy");
    a_start_idle: assert property ((eraseStart || programStart)
        |-> $past(chipSelectN) && !sleepActive)
        else $error("start while selected or asleep");
    a_rsv_zero: assert property (!statusAndProtect[BIT_RSV6])
        else $error("reserved bit set");
    a_bits_at_end: assert property ($changed(statusAndProtect[7:2])
        |-> !busy && ($past(busy) || $past(busy, 2)))
        else $error("protect bits changed outside cycle end");
    a_wel_rise: assert property ($rose(write_enable_latch)
        |-> !busy && !sleepActive) else $error("latch set while busy");
    a_wel_end: assert property ($fell(busy) |-> ##[0:1] !write_enable_latch)
        else $error("latch still set after cycle");
    a_standby_busy: assert property (standby |-> !busy)
        else $error("standby during internal cycle");
    a_dout_cs: assert property (dataOutEn |-> !$past(chipSelectN, 6))
        else $error("driving while deselected");
    a_busy_bound: assert property (busyCnt <= MAX_BUSY)
        else $error("busy never clears");

    c_erase: cover property (eraseStart);
    c_prog: cover property (programStart);
    c_sleep: cover property ($rose(sleepActive));
    c_read: cover property ($rose(dataOutEn));
endmodule

bind sfp_status_protect sfp_status_protect_properties #(
    .WRITE_CYCLES(WRITE_CYCLES),
    .PROG_CYCLES (PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
) u_props (.sys_clk, .nrst, .chipSelectN, .dataOutEn, .statusAndProtect,
           .eraseStart, .programStart, .standby, .sleepActive);

// *** sim/sfp_spi_host.sv ***
module sfp_spi_host (
    input  wire logic sys_clk,
    input  wire logic dataOut,
    output logic      spiClk,
    output logic      chipSelectN,
    output logic      dataIn
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF = 6;

    initial
    begin
        spiClk = 1'b0;
        chipSelectN = 1'b1;
        dataIn = 1'b0;
    end

    task automatic frame(input logic [31:0] bits, input int n,
                         output logic [15:0] rd);
        rd = 16'h0;
        @(negedge sys_clk);
        chipSelectN = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            dataIn = bits[31-i];
            repeat (HALF) @(negedge sys_clk);
            rd = {rd[14:0], dataOut};
            spiClk = 1'b1;
            repeat (HALF) @(negedge sys_clk);
            spiClk = 1'b0;
        end
        repeat (HALF) @(negedge sys_clk);
        chipSelectN = 1'b1;
        // Released line must not keep its last value
        dataIn = ~dataIn;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule

// *** sim/sfp_status_protect_tb.sv ***
module sfp_status_protect_tb
    import sfp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic              sys_clk = 1'b0;
    logic              nrst = 1'b0;
    logic              writeProtectN = 1'b1;
    logic              spiClk, chipSelectN, dataIn, dataOut, dataOutEn;
    logic              eraseStart, programStart, eraseChip, standby;
    logic              sleepActive;
    logic [7:0]        statusAndProtect;
    logic [ADDR_W-1:0] targetAddr;
    logic [15:0]       rd;
    int                num_errors = 0;
    int                cmp_count = 0;
    int                cycles = 0;
    int                eraseCnt = 0;
    int                progCnt = 0;

    sfp_status_protect #(.WRITE_CYCLES(150), .PROG_CYCLES(30),
        .ERASE_CYCLES(40)) u_sfp_status_protect (.sys_clk, .nrst, .spiClk,
        .chipSelectN, .dataIn, .writeProtectN, .dataOut, .dataOutEn,
        .statusAndProtect, .eraseStart, .programStart, .targetAddr,
        .eraseChip, .standby, .sleepActive);
    sfp_spi_host u_sfp_spi_host (.sys_clk, .dataOut, .spiClk, .chipSelectN,
        .dataIn);

    always #50 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        cycles++;
        if (eraseStart === 1'b1)
            eraseCnt++;
        if (programStart === 1'b1)
            progCnt++;
        if (cycles == 90000)
        begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic send(logic [31:0] b, int n);
        u_sfp_spi_host.frame(b, n, rd);
    endtask

    task automatic unlock();
        send({CMD_WRITE_UNLOCK, 24'h0}, 8);
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 200 && statusAndProtect[BIT_BUSY] !== 1'b0; k++)
            @(negedge sys_clk);
        cmp("busy", 0, statusAndProtect[BIT_BUSY]);
    endtask

    task automatic status_write_cmd(logic [7:0] v);
        unlock();
        send({CMD_STATUS_WRITE, v, 16'h0}, 16);
        wait_idle();
    endtask

    function automatic bit prot(int code, int tb, int blk);
        int n;
        n = code == 7 ? 64 : (code == 0 ? 0 : 1 << (code - 1));
        return tb ? blk < n : blk >= 64 - n;
    endfunction

    initial
    begin
        logic [7:0] ops [3];
        int         blk, ee, pe;
        bit         p, isProg;
        ops = '{CMD_SECTOR_WIPE, CMD_BLOCK_WIPE, CMD_PAGE_PROGRAM};
        repeat (16) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        cmp("status", 8'h00, statusAndProtect);
        cmp("sleep", 0, sleepActive);
        cmp("standby", 1, standby);
        send({CMD_STATUS_WRITE, 8'h0c, 16'h0}, 16);
        cmp("status", 8'h00, statusAndProtect);
        unlock();
        cmp("status", 8'h02, statusAndProtect);
        send({CMD_WRITE_LOCK, 24'h0}, 8);
        cmp("status", 8'h00, statusAndProtect);
        unlock();
        send({CMD_STATUS_WRITE, 8'h0c, 16'h0}, 15);
        cmp("status", 8'h02, statusAndProtect);
        send({CMD_STATUS_WRITE, 8'hff, 16'h0}, 16);
        cmp("busy", 1, statusAndProtect[BIT_BUSY]);
        cmp("standby", 0, standby);
        unlock();
        wait_idle();
        cmp("status", 8'hbc, statusAndProtect);
        cmp("standby", 1, standby);
        send({CMD_STATUS_READ, 24'h0}, 24);
        cmp("read", 16'hbcbc, rd);
        cmp("out enable", 0, dataOutEn);
        writeProtectN = 1'b0;
        unlock();
        send({CMD_STATUS_WRITE, 8'h00, 16'h0}, 16);
        cmp("status", 8'hbe, statusAndProtect);
        writeProtectN = 1'b1;
        send({CMD_STATUS_WRITE, 8'h00, 16'h0}, 16);
        wait_idle();
        cmp("status", 8'h00, statusAndProtect);
        for (int tb = 0; tb < 2; tb++)
            for (int code = 0; code < 8; code++)
            begin
                status_write_cmd({2'b00, tb[0], code[2:0], 2'b00});
                for (int j = 0; j < 2; j++)
                begin
                    blk = tb ? (code == 7 ? 63 + j : (1 << code >> 1) - 1 + j)
                             : 64 - (code == 7 ? 64 : 1 << code >> 1) - j;
                    blk = blk & 63;
                    p = prot(code, tb, blk);
                    isProg = ops[(code + j) % 3] == CMD_PAGE_PROGRAM;
                    ee = eraseCnt;
                    pe = progCnt;
                    unlock();
                    send({ops[(code + j) % 3], 2'b00, blk[5:0], 16'h0},
                         32);
                    cmp("program", !p && isProg, progCnt - pe);
                    cmp("erase", !p && !isProg, eraseCnt - ee);
                    if (!p)
                        cmp("addr", {blk[5:0], 16'h0}, targetAddr);
                    wait_idle();
                    cmp("latch", p, statusAndProtect[BIT_WEL]);
                end
            end
        status_write_cmd(8'h04);
        ee = eraseCnt;
        unlock();
        send({CMD_CHIP_WIPE, 24'h0}, 8);
        cmp("erase", 0, eraseCnt - ee);
        status_write_cmd(8'h00);
        unlock();
        send({CMD_CHIP_WIPE, 24'h0}, 8);
        cmp("erase", 1, eraseCnt - ee);
        cmp("chip", 1, eraseChip);
        wait_idle();
        send({CMD_SLEEP_ENTER, 24'h0}, 8);
        cmp("sleep", 1, sleepActive);
        unlock();
        cmp("status", 8'h00, statusAndProtect);
        send({CMD_SLEEP_EXIT, 24'h0}, 32);
        cmp("sleep", 0, sleepActive);
        unlock();
        cmp("status", 8'h02, statusAndProtect);
        results();
    end
endmodule
